// File: design/pmbc_top.sv
// bus-settings, range select and snapshot command registers
//
// Behaviour
// - bus settings readable, writable, effective immediately
// - bit 7 drives pin two open-drain
// - bit 6 drives pin one open-drain
// - alert summary follows enabled alerts, not count
// - power-on flag resets to one, host clears
// - bit 3 enables bus time-out detection
// - bit 2 adds byte count to block reads
// - bit 1 stops pointer skipping inactive channels
// - bit 0 selects narrow high-speed glitch filter
// - sense range fields per channel, bits 15-8
// - bus range fields per channel, bits 7-0
// - general-call snapshot is data-less, full snapshot
// - full snapshot copies results, clears accumulators
// - voltage-only snapshot copies, accumulators keep running
// - results valid within settle time, held after
// - bipolar range reports signed results
// - input-mode pin data bit reads pin level
`timescale 1ns/10ps

module pmbc_top #(
    parameter int unsigned SETTLE_CYCLES = pmbc_pkg::SNAP_CYCLES
) (
    input  wire logic                         mclk,          // 40 MHz clock
    input  wire logic                         arst_n,        // power-on reset
    input  pmbc_pkg::pmbc_req_t               req,           // register req
    output pmbc_pkg::pmbc_rsp_t               rsp,           // read answer
    input  wire logic [1:0]                   pin1_mode,     // pin one mode
    input  wire logic [1:0]                   pin2_mode,     // pin two mode
    input  wire logic                         multi_pin_one_in, // pin level
    input  wire logic                         multi_pin_two_in, // pin level
    output logic                              multi_pin_one_out, // always 0
    output logic                              multi_pin_one_oe,  // pull low
    output logic                              multi_pin_two_out, // always 0
    output logic                              multi_pin_two_oe,  // pull low
    input  wire logic [pmbc_pkg::ALERT_W-1:0] alert_active,  // enabled alerts
    output logic                              timeout_en,    // bus time-out
    output logic                              byte_count_en, // block count
    output logic                              no_skip,       // pointer mode
    output logic                              fast_bus_filter, // hs filter
    output logic [15:0]                       range_active,  // live ranges
    output logic [pmbc_pkg::NUM_CH-1:0]       sense_signed,  // signed sense
    output logic [pmbc_pkg::NUM_CH-1:0]       bus_signed,    // signed bus
    output logic                              snap_copy,     // copy pulse
    output logic                              accum_clear,   // clear pulse
    output logic                              results_valid  // results ready
);

    ////////////////////////////////////////////////////////////////////////
    // request decode

    logic wr_hit;
    logic rd_hit;
    logic snap_gen;
    logic snap_volt;

    // commands only count as plain send bytes; a data byte voids them
    assign wr_hit    = req.valid & req.write & ~req.send_only
                       & ~req.general_call;
    assign rd_hit    = req.valid & ~req.write & ~req.general_call;
    assign snap_gen  = req.valid & req.write & req.send_only
                       & (req.addr == pmbc_pkg::OFF_SNAP_GEN);
    assign snap_volt = req.valid & req.write & req.send_only
                       & ~req.general_call
                       & (req.addr == pmbc_pkg::OFF_SNAP_VOLT);

    ////////////////////////////////////////////////////////////////////////
    // configuration registers

    logic [7:0]  bus_set_q;
    logic [7:0]  bus_set_d;
    logic [15:0] range_sel_q;
    logic [15:0] range_sel_d;
    logic [15:0] range_act_q;
    logic [15:0] range_act_d;

    // settings apply on the write itself, no snapshot involved
    always_comb begin
        bus_set_d   = bus_set_q;
        range_sel_d = range_sel_q;
        range_act_d = range_act_q;
        // summary flag mirrors live sources; the count alarm is not one
        bus_set_d[pmbc_pkg::BIT_ANY_ALERT] = |alert_active;
        if (wr_hit && req.addr == pmbc_pkg::OFF_BUS_SETTINGS) begin
            bus_set_d[pmbc_pkg::BIT_PIN2_LEVEL] =
                req.data[pmbc_pkg::BIT_PIN2_LEVEL];
            bus_set_d[pmbc_pkg::BIT_PIN1_LEVEL] =
                req.data[pmbc_pkg::BIT_PIN1_LEVEL];
            bus_set_d[pmbc_pkg::BIT_TIMEOUT_EN] =
                req.data[pmbc_pkg::BIT_TIMEOUT_EN];
            bus_set_d[pmbc_pkg::BIT_BYTE_COUNT] =
                req.data[pmbc_pkg::BIT_BYTE_COUNT];
            bus_set_d[pmbc_pkg::BIT_NO_SKIP] =
                req.data[pmbc_pkg::BIT_NO_SKIP];
            bus_set_d[pmbc_pkg::BIT_FAST_FILTER] =
                req.data[pmbc_pkg::BIT_FAST_FILTER];
            // writing one cannot set it again; only reset does
            bus_set_d[pmbc_pkg::BIT_POR] = bus_set_q[pmbc_pkg::BIT_POR]
                & req.data[pmbc_pkg::BIT_POR];
        end
        if (wr_hit && req.addr == pmbc_pkg::OFF_RANGE_SEL) begin
            range_sel_d = req.data;
        end
        // pending ranges go live only with the full snapshot
        if (snap_gen) begin
            range_act_d = range_sel_q;
        end
    end

    // configuration storage
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            bus_set_q   <= pmbc_pkg::BUS_SETTINGS_RST;
            range_sel_q <= pmbc_pkg::RANGE_SEL_RST;
            range_act_q <= pmbc_pkg::RANGE_SEL_RST;
        end else begin
            bus_set_q   <= bus_set_d;
            range_sel_q <= range_sel_d;
            range_act_q <= range_act_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // per-channel sign flags from the live ranges

    logic [pmbc_pkg::NUM_CH-1:0] sense_sg_d;
    logic [pmbc_pkg::NUM_CH-1:0] bus_sg_d;

    // any non-unipolar code turns the result to two's complement
    for (genvar ch = 0; ch < pmbc_pkg::NUM_CH; ch++) begin : g_sign
        assign sense_sg_d[ch] = range_act_d[pmbc_pkg::SENSE_TOP
            - pmbc_pkg::RANGE_W * ch -: pmbc_pkg::RANGE_W]
            != pmbc_pkg::RANGE_UNIPOLAR;
        assign bus_sg_d[ch] = range_act_d[pmbc_pkg::BUS_TOP
            - pmbc_pkg::RANGE_W * ch -: pmbc_pkg::RANGE_W]
            != pmbc_pkg::RANGE_UNIPOLAR;
    end

    ////////////////////////////////////////////////////////////////////////
    // pin drive and read answer

    logic      pin1_oe_d;
    logic      pin2_oe_d;
    logic [7:0] bus_rd;
    pmbc_pkg::pmbc_rsp_t rsp_d;

    // open drain: a zero level pulls low, a one lets the resistor pull up
    always_comb begin
        pin1_oe_d = (pin1_mode == pmbc_pkg::PIN_MODE_OUTPUT)
                    & ~bus_set_d[pmbc_pkg::BIT_PIN1_LEVEL];
        pin2_oe_d = (pin2_mode == pmbc_pkg::PIN_MODE_OUTPUT)
                    & ~bus_set_d[pmbc_pkg::BIT_PIN2_LEVEL];
        bus_rd = bus_set_q;
        if (pin1_mode == pmbc_pkg::PIN_MODE_INPUT) begin
            bus_rd[pmbc_pkg::BIT_PIN1_LEVEL] = multi_pin_one_in;
        end
        if (pin2_mode == pmbc_pkg::PIN_MODE_INPUT) begin
            bus_rd[pmbc_pkg::BIT_PIN2_LEVEL] = multi_pin_two_in;
        end
        rsp_d.valid = rd_hit;
        rsp_d.data  = 16'h0000;
        // command offsets and unmapped pointers read as zero
        if (rd_hit) begin
            case (req.addr)
                pmbc_pkg::OFF_BUS_SETTINGS: rsp_d.data = {8'h00, bus_rd};
                pmbc_pkg::OFF_RANGE_SEL:    rsp_d.data = range_sel_q;
                default:                    rsp_d.data = 16'h0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // snapshot sequencing

    pmbc_pkg::pmbc_res_state_t st_q;
    pmbc_pkg::pmbc_res_state_t st_d;
    logic [pmbc_pkg::CNT_W-1:0] cnt_q;
    logic [pmbc_pkg::CNT_W-1:0] cnt_d;
    logic                       copy_d;
    logic                       clr_d;
    logic                       valid_d;

    // a new snapshot restarts the settle window even mid-count
    always_comb begin
        st_d   = st_q;
        cnt_d  = cnt_q;
        copy_d = snap_gen | snap_volt;
        clr_d  = snap_gen;
        case (st_q)
            pmbc_pkg::RES_IDLE: begin
                cnt_d = '0;
            end
            pmbc_pkg::RES_SETTLE: begin
                if (cnt_q == pmbc_pkg::CNT_W'(SETTLE_CYCLES - 1)) begin
                    st_d = pmbc_pkg::RES_VALID;
                end else begin
                    cnt_d = cnt_q + pmbc_pkg::CNT_W'(1);
                end
            end
            pmbc_pkg::RES_VALID: begin
                cnt_d = '0;
            end
            default: begin
                st_d  = pmbc_pkg::RES_IDLE;
                cnt_d = '0;
            end
        endcase
        if (copy_d) begin
            st_d  = pmbc_pkg::RES_SETTLE;
            cnt_d = '0;
        end
        // registered so the ready flag is a clean flop output
        valid_d = (st_d == pmbc_pkg::RES_VALID);
    end

    // sequencer and output registers
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            st_q              <= pmbc_pkg::RES_IDLE;
            cnt_q             <= '0;
            snap_copy         <= 1'b0;
            accum_clear       <= 1'b0;
            rsp               <= '0;
            multi_pin_one_oe  <= 1'b0;
            multi_pin_two_oe  <= 1'b0;
            multi_pin_one_out <= 1'b0;
            multi_pin_two_out <= 1'b0;
            sense_signed      <= '0;
            bus_signed        <= '0;
            results_valid     <= 1'b0;
        end else begin
            st_q              <= st_d;
            cnt_q             <= cnt_d;
            snap_copy         <= copy_d;
            accum_clear       <= clr_d;
            rsp               <= rsp_d;
            multi_pin_one_oe  <= pin1_oe_d;
            multi_pin_two_oe  <= pin2_oe_d;
            multi_pin_one_out <= 1'b0;
            multi_pin_two_out <= 1'b0;
            sense_signed      <= sense_sg_d;
            bus_signed        <= bus_sg_d;
            results_valid     <= valid_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs taken straight from registers

    assign timeout_en      = bus_set_q[pmbc_pkg::BIT_TIMEOUT_EN];
    assign byte_count_en   = bus_set_q[pmbc_pkg::BIT_BYTE_COUNT];
    assign no_skip         = bus_set_q[pmbc_pkg::BIT_NO_SKIP];
    assign fast_bus_filter = bus_set_q[pmbc_pkg::BIT_FAST_FILTER];
    assign range_active    = range_act_q;

endmodule

// File: design/pmbc_pkg.sv
// shared constants and carrier types of the bus-config and snapshot block
package pmbc_pkg;

    // register offsets on the serial register port
    localparam logic [7:0] OFF_BUS_SETTINGS = 8'h1c;
    localparam logic [7:0] OFF_RANGE_SEL    = 8'h1d;
    localparam logic [7:0] OFF_SNAP_GEN     = 8'h1e;
    localparam logic [7:0] OFF_SNAP_VOLT    = 8'h1f;

    // bus-settings field positions
    localparam int BIT_PIN2_LEVEL  = 7;
    localparam int BIT_PIN1_LEVEL  = 6;
    localparam int BIT_ANY_ALERT   = 5;
    localparam int BIT_POR         = 4;
    localparam int BIT_TIMEOUT_EN  = 3;
    localparam int BIT_BYTE_COUNT  = 2;
    localparam int BIT_NO_SKIP     = 1;
    localparam int BIT_FAST_FILTER = 0;

    // reset values
    localparam logic [7:0]  BUS_SETTINGS_RST = 8'h10;
    localparam logic [15:0] RANGE_SEL_RST    = 16'h0000;

    // range field layout: channel 1 at the top of each byte
    localparam int         NUM_CH        = 4;
    localparam int         SENSE_TOP     = 15;
    localparam int         BUS_TOP       = 7;
    localparam int         RANGE_W       = 2;
    localparam logic [1:0] RANGE_UNIPOLAR = 2'h0;

    // multi-function pin mode codes from the active control image
    localparam logic [1:0] PIN_MODE_INPUT  = 2'h1;
    localparam logic [1:0] PIN_MODE_OUTPUT = 2'h2;

    // number of alert sources feeding the summary flag
    localparam int ALERT_W = 8;

    // result settling time after a snapshot
    localparam int unsigned SNAP_TIME_US = 1000;
    localparam int unsigned CLK_KHZ      = 40000;
    localparam int unsigned SNAP_CYCLES  = SNAP_TIME_US * CLK_KHZ / 1000;
    localparam int          CNT_W        = 17;

    // one decoded transaction from the serial target front end
    typedef struct packed {
        logic        valid;        // one-cycle strobe
        logic        write;        // 1 write, 0 read
        logic        send_only;    // send byte, no data byte followed
        logic        general_call; // arrived on the general call address
        logic [7:0]  addr;         // register pointer
        logic [15:0] data;         // write data, low byte for 8-bit regs
    } pmbc_req_t;

    // read answer back to the front end
    typedef struct packed {
        logic        valid;        // one-cycle strobe
        logic [15:0] data;         // read data, zero above register width
    } pmbc_rsp_t;

    typedef enum logic [1:0] {
        RES_IDLE,
        RES_SETTLE,
        RES_VALID
    } pmbc_res_state_t;

endpackage

// File: dv/pmbc_assertions.sv
// port-level assertions for the bus-config and snapshot block
`timescale 1ns/10ps
module pmbc_checker #(
    parameter int unsigned SETTLE_CYCLES = 8
) (
    input wire logic          mclk,             // clock
    input wire logic          arst_n,           // reset
    input pmbc_pkg::pmbc_req_t req,             // request
    input pmbc_pkg::pmbc_rsp_t rsp,             // answer
    input wire logic [1:0]    pin1_mode,        // pin one mode
    input wire logic [1:0]    pin2_mode,        // pin two mode
    input wire logic          multi_pin_one_oe, // pin one pull low
    input wire logic          multi_pin_two_oe, // pin two pull low
    input wire logic [7:0]    alert_active,     // alert sources
    input wire logic          timeout_en,       // bit 3
    input wire logic          byte_count_en,    // bit 2
    input wire logic          no_skip,          // bit 1
    input wire logic          fast_bus_filter,  // bit 0
    input wire logic [15:0]   range_active,     // live ranges
    input wire logic          snap_copy,        // copy pulse
    input wire logic          accum_clear,      // clear pulse
    input wire logic          results_valid     // results ready
);
    logic        wr_cfg, rd_cfg, wr_rng, snap, seen_q;
    logic [16:0] cnt_q;
    ////////////////////////////////////////////////////////////////////
    // decoded requests
    assign wr_cfg = req.valid && req.write && !req.send_only
        && !req.general_call && req.addr == pmbc_pkg::OFF_BUS_SETTINGS;
    assign wr_rng = req.valid && req.write && !req.send_only
        && !req.general_call && req.addr == pmbc_pkg::OFF_RANGE_SEL;
    assign rd_cfg = req.valid && !req.write && !req.general_call
        && req.addr == pmbc_pkg::OFF_BUS_SETTINGS;
    // volt-only snapshot is never taken through general call
    assign snap = req.valid && req.write && req.send_only
        && (req.addr == pmbc_pkg::OFF_SNAP_GEN
        || (req.addr == pmbc_pkg::OFF_SNAP_VOLT && !req.general_call));
    // cycles since the last snapshot, saturating so it never wraps
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q  <= '0;
            seen_q <= 1'b0;
        end else if (snap) begin
            cnt_q  <= '0;
            seen_q <= 1'b1;
        end else if (cnt_q != '1) begin
            cnt_q  <= cnt_q + 17'h1;
        end
    end
    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    sequence full_snap_s;
        snap && req.addr == pmbc_pkg::OFF_SNAP_GEN;
    endsequence
    sequence volt_snap_s;
        snap && req.addr == pmbc_pkg::OFF_SNAP_VOLT;
    endsequence
    read_answer_a: assert property (
        req.valid && !req.write && !req.general_call |=> rsp.valid)
        else $error("no answer");
    cfg_apply_a: assert property (
        wr_cfg |=> {timeout_en, byte_count_en, no_skip, fast_bus_filter}
        == $past(req.data[3:0])) else $error("settings not applied");
    pin_two_low_a: assert property (
        wr_cfg && pin2_mode == pmbc_pkg::PIN_MODE_OUTPUT && !req.data[7]
        |=> multi_pin_two_oe) else $error("pin two not pulled low");
    pin_one_free_a: assert property (
        wr_cfg && pin1_mode == pmbc_pkg::PIN_MODE_OUTPUT && req.data[6]
        |=> !multi_pin_one_oe) else $error("pin one not released");
    alert_mirror_a: assert property (
        rd_cfg && $stable(alert_active) |=> rsp.data[5]
        == |$past(alert_active)) else $error("alert flag wrong");
    full_snap_a: assert property (
        full_snap_s |=> snap_copy && accum_clear && !results_valid)
        else $error("full snapshot pulses wrong");
    volt_snap_a: assert property (
        volt_snap_s |=> snap_copy && !accum_clear)
        else $error("voltage snapshot pulses wrong");
    range_hold_a: assert property (
        wr_rng && !snap |=> $stable(range_active))
        else $error("range went live without snapshot");
    settle_time_a: assert property (
        results_valid == (seen_q && cnt_q >= SETTLE_CYCLES))
        else $error("results valid at wrong time");
endmodule

bind pmbc_top pmbc_checker #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_chk (
    .mclk(mclk), .arst_n(arst_n), .req(req), .rsp(rsp),
    .pin1_mode(pin1_mode), .pin2_mode(pin2_mode),
    .multi_pin_one_oe(multi_pin_one_oe),
    .multi_pin_two_oe(multi_pin_two_oe), .alert_active(alert_active),
    .timeout_en(timeout_en), .byte_count_en(byte_count_en),
    .no_skip(no_skip), .fast_bus_filter(fast_bus_filter),
    .range_active(range_active), .snap_copy(snap_copy),
    .accum_clear(accum_clear), .results_valid(results_valid));

// File: dv/pmbc_host.sv
// host model issuing decoded register requests to the block
`timescale 1ns/10ps
module pmbc_host #(
    parameter int unsigned SETTLE_CYCLES = 8
) (
    input  wire logic          mclk, // clock
    output pmbc_pkg::pmbc_req_t req,  // request
    input  pmbc_pkg::pmbc_rsp_t rsp   // answer
);
    initial req = '0;
    ////////////////////////////////////////////////////////////////////
    // one request per falling edge; held until the next call
    task automatic put(input logic w, s, g, input logic [7:0] a,
                       input logic [15:0] d);
        @(negedge mclk);
        req <= {1'b1, w, s, g, a, d};
    endtask
    task automatic idle();
        @(negedge mclk);
        req <= '0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        put(1'b1, 1'b0, 1'b0, a, d);
        idle();
    endtask
    // answer stands for the one cycle after the take
    task automatic rd(input logic [7:0] a, output logic [15:0] d,
                      output logic v);
        put(1'b0, 1'b0, 1'b0, a, 16'h0000);
        idle();
        v = rsp.valid;
        d = rsp.data;
    endtask
    // send byte only, no data byte follows
    task automatic snap(input logic g, input logic [7:0] a);
        put(1'b1, 1'b1, g, a, 16'h0000);
        idle();
    endtask
    // results are only trusted after the settle time
    task automatic settle();
        repeat (SETTLE_CYCLES + 2) @(negedge mclk);
    endtask
endmodule

// File: dv/test_power_monitor_bus_config_snapshot.sv
// self-checking bench for the bus-config and snapshot block
`timescale 1ns/10ps
module test_power_monitor_bus_config_snapshot;
    localparam int unsigned SETTLE = 8;
    logic                mclk, arst_n, ext1, ext2, one_oe, two_oe;
    logic                out1, out2;
    logic                one_in, two_in, tmo, bce, nsk, fbf, rd_v;
    logic                snap_copy, accum_clear, results_valid;
    logic [1:0]          pin1_mode, pin2_mode;
    logic [7:0]          alert_active;
    logic [15:0]         range_active, rd_d;
    logic [3:0]          sense_signed, bus_signed;
    pmbc_pkg::pmbc_req_t req;
    pmbc_pkg::pmbc_rsp_t rsp;
    int                  errors, n_compared, cycles;
    ////////////////////////////////////////////////////////////////////
    // open-drain pins: pulled up unless something pulls them low
    assign one_in = one_oe ? 1'b0 : ext1;
    assign two_in = two_oe ? 1'b0 : ext2;
    pmbc_host #(.SETTLE_CYCLES(SETTLE)) host (
        .mclk(mclk), .req(req), .rsp(rsp));
    pmbc_top #(.SETTLE_CYCLES(SETTLE)) uut (
        .mclk(mclk), .arst_n(arst_n), .req(req), .rsp(rsp),
        .pin1_mode(pin1_mode), .pin2_mode(pin2_mode),
        .multi_pin_one_in(one_in), .multi_pin_two_in(two_in),
        .multi_pin_one_out(out1), .multi_pin_one_oe(one_oe),
        .multi_pin_two_out(out2), .multi_pin_two_oe(two_oe),
        .alert_active(alert_active), .timeout_en(tmo),
        .byte_count_en(bce), .no_skip(nsk), .fast_bus_filter(fbf),
        .range_active(range_active), .sense_signed(sense_signed),
        .bus_signed(bus_signed), .snap_copy(snap_copy),
        .accum_clear(accum_clear), .results_valid(results_valid));
    initial mclk = 1'b0;
    always #12.5 mclk = ~mclk;
    ////////////////////////////////////////////////////////////////////
    task automatic final_report();
        if (errors == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, g);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rdchk(input string nm, input logic [7:0] a,
                         input logic [15:0] e);
        host.rd(a, rd_d, rd_v);
        chk("read valid", 16'h0001, {15'h0, rd_v});
        chk(nm, e, rd_d);
    endtask
    // hang guard well above the expected run length
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            final_report();
        end
    end
    ////////////////////////////////////////////////////////////////////
    task automatic t_reset_values();
        rdchk("settings", 8'h1c, 16'h0010);
        rdchk("range", 8'h1d, 16'h0000);
        rdchk("unmapped", 8'h30, 16'h0000);
    endtask
    task automatic t_settings();
        host.wr(8'h1c, 16'h00ff);
        chk("cfg", 16'h000f, {12'h0, tmo, bce, nsk, fbf});
        chk("oe high", 16'h0000, {14'h0, two_oe, one_oe});
        chk("pin out", 16'h0000, {14'h0, out2, out1});
        rdchk("settings", 8'h1c, 16'h00df);
        host.wr(8'h1c, 16'h0000);
        chk("cfg", 16'h0000, {12'h0, tmo, bce, nsk, fbf});
        chk("oe low", 16'h0003, {14'h0, two_oe, one_oe});
        chk("pins", 16'h0000, {14'h0, two_in, one_in});
        host.wr(8'h1c, 16'h0010);
        rdchk("por", 8'h1c, 16'h0000);
    endtask
    // input mode reads the pin, not the stored bits
    task automatic t_pin_input();
        pin1_mode = 2'h1;
        pin2_mode = 2'h1;
        ext1 = 1'b0;
        host.wr(8'h1c, 16'h00c0);
        chk("oe input", 16'h0000, {14'h0, two_oe, one_oe});
        rdchk("pin level", 8'h1c, 16'h0080);
    endtask
    task automatic t_alert();
        alert_active = 8'h20;
        repeat (2) @(negedge mclk);
        rdchk("alert set", 8'h1c, 16'h00a0);
        alert_active = 8'h00;
        repeat (2) @(negedge mclk);
        rdchk("alert clear", 8'h1c, 16'h0080);
    endtask
    task automatic t_snapshots();
        host.wr(8'h1d, 16'h5a3c);
        rdchk("range", 8'h1d, 16'h5a3c);
        chk("pending", 16'h0000, range_active);
        host.snap(1'b0, 8'h1f);
        chk("volt snap", 16'h0004, {13'h0, snap_copy, accum_clear,
            results_valid});
        chk("not live", 16'h0000, range_active);
        host.settle();
        chk("settled", 16'h0001, {15'h0, results_valid});
        host.snap(1'b1, 8'h1f);
        chk("gc volt", 16'h0001, {13'h0, snap_copy, accum_clear,
            results_valid});
        host.wr(8'h1e, 16'h00ff);
        chk("data write", 16'h0000, {14'h0, snap_copy, accum_clear});
        host.snap(1'b1, 8'h1e);
        chk("gc snap", 16'h0006, {13'h0, snap_copy, accum_clear,
            results_valid});
        chk("live", 16'h5a3c, range_active);
        chk("signed", 16'h00f6, {8'h0, sense_signed, bus_signed});
        host.put(1'b1, 1'b1, 1'b0, 8'h1e, 16'h0000);
        host.put(1'b1, 1'b1, 1'b0, 8'h1f, 16'h0000);
        host.idle();
        chk("back to back", 16'h0004, {13'h0, snap_copy, accum_clear,
            results_valid});
        host.settle();
        chk("settled", 16'h0001, {15'h0, results_valid});
    endtask
    // a second power-on reset brings back the flag and the defaults
    task automatic t_power_cycle();
        @(negedge mclk);
        arst_n = 1'b0;
        repeat (2) @(negedge mclk);
        chk("reset pulses", 16'h0000, {13'h0, snap_copy, accum_clear,
            results_valid});
        chk("reset range", 16'h0000, range_active);
        chk("reset signs", 16'h0000, {8'h0, sense_signed, bus_signed});
        arst_n = 1'b1;
        rdchk("por again", 8'h1c, 16'h0090);
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        errors = 0;
        n_compared = 0;
        cycles = 0;
        arst_n = 1'b0;
        pin1_mode = 2'h2;
        pin2_mode = 2'h2;
        ext1 = 1'b1;
        ext2 = 1'b1;
        alert_active = 8'h00;
        repeat (3) @(posedge mclk);
        @(negedge mclk);
        arst_n = 1'b1;
        t_reset_values();
        t_settings();
        t_pin_input();
        t_alert();
        t_snapshots();
        t_power_cycle();
        final_report();
    end
endmodule
